/* File: pkg/msf_pkg.sv */
// Shared constants for the minislot MAC framer and slot access logic
// How it works
// (RL1) Ranging slot neighbours stay unused by others
// (RL2) Range only if flag was 1 or boundary 55..63
// (RL3) Assigned ranging slot blocks general ranging until passed
// (RL4) Fixed-rate data only in exclusively assigned slots
// (RL5) Reservation data only after grant arrives
// (RL6) Reservation grants honoured in fixed-rate region too
// (RL7) Same message body in minislot and cell slot
// (RL8) Burst opens with unique word 00 fc fc f3
// (RL9) Start field bit 7 set, others zero
// (RL10) Encoder covers the 14 bytes after unique word
// (RL11) Two parity bytes make a 16-byte codeword
// (RL12) Encode first, randomize afterwards
// (RL13) Shortened code equals 239 leading zero bytes
// (RL14) Generator roots mu^0, mu^1 over field 0x11d
// (RL15) Singlecast uses full 48-bit MAC address
// (RL16) Type 0x00 means fragment continuation
// (RL17) Parity follows info bytes, then guard band
// (RL18) Parity registers cleared at each burst start
package msf_pkg;
  localparam logic [31:0] UNIQUE_WORD     = 32'h00fcfcf3;
  localparam logic [7:0]  START_FIELD     = 8'h80;
  localparam logic [7:0]  FIELD_POLY_LOW  = 8'h1d;
  localparam int          INFO_BYTES      = 14;
  localparam int          UW_BYTES        = 4;
  localparam int          PARITY_BYTES    = 2;
  localparam int          MSG_BYTES       = INFO_BYTES - 1;
  localparam int          GUARD_BYTES     = 2;
  localparam logic [5:0]  BOUNDARY_MIN    = 6'h37;
  localparam logic [5:0]  BOUNDARY_MAX    = 6'h3f;
  localparam logic [7:0]  TYPE_CONTINUE   = 8'h00;
  localparam int          SLOT_W          = 13;
  localparam int          CNT_W           = 16;
  typedef enum logic [2:0]
  {
    MSF_IDLE   = 3'b000,
    MSF_UW     = 3'b001,
    MSF_SF     = 3'b010,
    MSF_BODY   = 3'b011,
    MSF_PARITY = 3'b100,
    MSF_GUARD  = 3'b101
  } msf_state_type;
  typedef enum logic [1:0]
  {
    MSF_ACC_RANGING  = 2'b00,
    MSF_ACC_FIXED    = 2'b01,
    MSF_ACC_RESERVED = 2'b10
  } msf_access_type;
endpackage : msf_pkg

/* File: pkg/msf_link_if.sv */
// Link between the subscriber unit framer and the head end slot controller
`timescale 1ns/1ns
`default_nettype none
interface msf_link_if;
  logic [15:0] slot_count;
  logic        ranging_region_flag;
  logic [5:0]  slot_boundary_value;
  logic        ranging_region_now;
  logic        fixed_region_now;
  logic        resv_region_now;
  logic        fixed_assign;
  logic        resv_grant;
  logic        ranging_assign;
  logic [12:0] assign_slot;
  logic [7:0]  up_byte;
  logic        up_valid;
  logic        up_start;
  logic        up_access;
  modport unit
  (
    input  slot_count, ranging_region_flag, slot_boundary_value,
    input  ranging_region_now, fixed_region_now, resv_region_now,
    input  fixed_assign, resv_grant, ranging_assign, assign_slot,
    output up_byte, up_valid, up_start, up_access
  );
  modport head
  (
    output slot_count, ranging_region_flag, slot_boundary_value,
    output ranging_region_now, fixed_region_now, resv_region_now,
    output fixed_assign, resv_grant, ranging_assign, assign_slot,
    input  up_byte, up_valid, up_start, up_access
  );
endinterface : msf_link_if
`default_nettype wire

/* File: logic/msf_unit.sv */
// Subscriber unit end: slot access gating and minislot MAC burst framer
`timescale 1ns/1ns
`default_nettype none
module msf_unit
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  msf_link_if.unit              link,
  input  wire logic             req_valid,
  input  wire logic [1:0]       req_access,
  input  wire logic [7:0]       req_type,
  input  wire logic             req_singlecast,
  input  wire logic [47:0]      req_mac_addr,
  input  wire logic [55:0]      req_payload,
  output logic                  req_ready,
  output logic                  burst_done,
  output logic                  ranging_allowed
);
  // GF(2^8) multiply by 2 with the field polynomial
  function automatic logic [7:0] msf_xtime(input logic [7:0] v);
    msf_xtime = {v[6:0], 1'b0} ^ (v[7] ? msf_pkg::FIELD_POLY_LOW : 8'h00); // [RL14]
  endfunction : msf_xtime

  msf_pkg::msf_state_type state_r, state_nxt;
  logic [3:0]   idx_r, idx_nxt;
  logic [7:0]   p0_r, p0_nxt, p1_r, p1_nxt;
  logic [111:0] body_r, body_nxt;
  logic [7:0]   byte_r, byte_nxt;
  logic         valid_r, valid_nxt, start_r, start_nxt, done_r, done_nxt;
  logic [1:0]   acc_r, acc_nxt;
  logic         flag_seen_r, flag_seen_nxt;
  logic         rng_hold_r, rng_hold_nxt;
  logic [12:0]  rng_slot_r, rng_slot_nxt;
  logic         fix_own_r, fix_own_nxt, grant_r, grant_nxt;
  logic [12:0]  own_slot_r, own_slot_nxt;
  logic         slot_hit, may_send;
  logic [7:0]   info, fb;

  // Slot permission; the head end keeps ranging neighbours clear [RL1]
  always_comb
  begin
    slot_hit = link.slot_count[12:0] == own_slot_r;
    ranging_allowed = !rng_hold_r && link.ranging_region_now &&
      (flag_seen_r || (link.slot_boundary_value >= msf_pkg::BOUNDARY_MIN &&
                       link.slot_boundary_value <= msf_pkg::BOUNDARY_MAX)); // [RL2] [RL3]
    unique case (req_access)
      2'b00:   may_send = ranging_allowed ||
                          (rng_hold_r && link.slot_count[12:0] == rng_slot_r);
      2'b01:   may_send = fix_own_r && slot_hit && link.fixed_region_now; // [RL4]
      default: may_send = grant_r && slot_hit &&
                          (link.resv_region_now || link.fixed_region_now); // [RL5] [RL6]
    endcase
  end
  assign req_ready = (state_r == msf_pkg::MSF_IDLE) && may_send;

  // Message body is laid out as in a cell slot: type, address, payload [RL7] [RL15] [RL16]
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    p0_nxt = p0_r;
    p1_nxt = p1_r;
    body_nxt = body_r;
    byte_nxt = 8'h00;
    valid_nxt = 1'b0;
    start_nxt = 1'b0;
    done_nxt = 1'b0;
    acc_nxt = acc_r;
    info = 8'h00;
    fb = 8'h00;
    flag_seen_nxt = flag_seen_r;
    rng_hold_nxt = rng_hold_r;
    rng_slot_nxt = rng_slot_r;
    fix_own_nxt = fix_own_r;
    grant_nxt = grant_r;
    own_slot_nxt = own_slot_r;
    // Flag sampled only at slot count zero, once every eight superframes; takes effect from the next slot
    if (link.slot_count[15:13] == 3'h0 && link.slot_count[12:0] == 13'h0000)
      flag_seen_nxt = link.ranging_region_flag; // [RL2]
    if (link.ranging_assign)
    begin
      rng_hold_nxt = 1'b1;
      rng_slot_nxt = link.assign_slot;
    end
    else if (rng_hold_r && link.slot_count[12:0] == rng_slot_r)
      rng_hold_nxt = 1'b0; // [RL3]
    if (link.fixed_assign)
    begin
      fix_own_nxt = 1'b1;
      own_slot_nxt = link.assign_slot;
    end
    if (link.resv_grant)
    begin
      grant_nxt = 1'b1;
      own_slot_nxt = link.assign_slot;
    end
    unique case (state_r)
      msf_pkg::MSF_IDLE:
        if (req_valid && may_send)
        begin
          body_nxt = {msf_pkg::START_FIELD, req_type, req_singlecast ? req_mac_addr : 48'h0,
                      req_payload[55:8]}; // [RL9]
          acc_nxt = req_access;
          idx_nxt = 4'h0;
          p0_nxt = 8'h00;
          p1_nxt = 8'h00; // [RL18]
          state_nxt = msf_pkg::MSF_UW;
          // Both reservation codes use the grant up; a fresh grant this cycle survives
          if (req_access[1] && !link.resv_grant)
            grant_nxt = 1'b0; // Grant used once [RL5]
        end
      msf_pkg::MSF_UW:
      begin
        byte_nxt = msf_pkg::UNIQUE_WORD[31 - 8 * idx_r -: 8]; // [RL8]
        valid_nxt = 1'b1;
        start_nxt = idx_r == 4'h0;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'(msf_pkg::UW_BYTES - 1))
        begin
          idx_nxt = 4'h0;
          state_nxt = msf_pkg::MSF_BODY;
        end
      end
      msf_pkg::MSF_BODY:
      begin
        // LFSR over the 14 info bytes; leading zeros leave it at zero [RL10] [RL13]
        info = body_r[111:104];
        fb = info ^ p1_r;
        p1_nxt = p0_r ^ msf_xtime(fb) ^ fb; // g = x^2 + 3x + 2 [RL14]
        p0_nxt = msf_xtime(fb);
        body_nxt = {body_r[103:0], 8'h00};
        byte_nxt = info;
        valid_nxt = 1'b1;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'(msf_pkg::INFO_BYTES - 1))
        begin
          idx_nxt = 4'h0;
          state_nxt = msf_pkg::MSF_PARITY;
        end
      end
      msf_pkg::MSF_PARITY:
      begin
        // Parity directly follows info; randomizer lies downstream [RL11] [RL12] [RL17]
        byte_nxt = (idx_r == 4'h0) ? p1_r : p0_r;
        valid_nxt = 1'b1;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'(msf_pkg::PARITY_BYTES - 1))
        begin
          idx_nxt = 4'h0;
          state_nxt = msf_pkg::MSF_GUARD;
        end
      end
      msf_pkg::MSF_GUARD:
      begin
        idx_nxt = idx_r + 4'h1; // Silent guard before next burst [RL17]
        if (idx_r == 4'(msf_pkg::GUARD_BYTES - 1))
        begin
          idx_nxt = 4'h0;
          done_nxt = 1'b1;
          state_nxt = msf_pkg::MSF_IDLE;
        end
      end
      default:
        state_nxt = msf_pkg::MSF_IDLE;
    endcase
  end

  // Register stage only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= msf_pkg::MSF_IDLE;
      idx_r <= 4'h0;
      p0_r <= 8'h00;
      p1_r <= 8'h00;
      body_r <= 112'h0;
      byte_r <= 8'h00;
      valid_r <= 1'b0;
      start_r <= 1'b0;
      done_r <= 1'b0;
      acc_r <= 2'b00;
      flag_seen_r <= 1'b0;
      rng_hold_r <= 1'b0;
      rng_slot_r <= 13'h0000;
      fix_own_r <= 1'b0;
      grant_r <= 1'b0;
      own_slot_r <= 13'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      p0_r <= p0_nxt;
      p1_r <= p1_nxt;
      body_r <= body_nxt;
      byte_r <= byte_nxt;
      valid_r <= valid_nxt;
      start_r <= start_nxt;
      done_r <= done_nxt;
      acc_r <= acc_nxt;
      flag_seen_r <= flag_seen_nxt;
      rng_hold_r <= rng_hold_nxt;
      rng_slot_r <= rng_slot_nxt;
      fix_own_r <= fix_own_nxt;
      grant_r <= grant_nxt;
      own_slot_r <= own_slot_nxt;
    end
  end

  assign link.up_byte = byte_r;
  assign link.up_valid = valid_r;
  assign link.up_start = start_r;
  assign link.up_access = acc_r != 2'b00;
  assign burst_done = done_r;
endmodule : msf_unit
`default_nettype wire

/* File: logic/msf_head.sv */
// Head end: slot counter, region markers, assignments, burst capture
`timescale 1ns/1ns
`default_nettype none
module msf_head
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  msf_link_if.head              link,
  input  wire logic             cfg_ranging_flag,
  input  wire logic [5:0]       cfg_boundary,
  input  wire logic [12:0]      cfg_ranging_end,
  input  wire logic [12:0]      cfg_fixed_end,
  input  wire logic             cmd_fixed,
  input  wire logic             cmd_grant,
  input  wire logic             cmd_ranging,
  input  wire logic [12:0]      cmd_slot,
  output logic [7:0]            rx_byte,
  output logic                  rx_valid,
  output logic                  rx_start
);
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0]  rb_r, rb_nxt;
  logic        rv_r, rv_nxt, rs_r, rs_nxt;

  // Slot counter and byte capture
  always_comb
  begin
    cnt_nxt = cnt_r + 16'h0001;
    rb_nxt = link.up_byte;
    rv_nxt = link.up_valid;
    rs_nxt = link.up_start;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 16'h0000;
      rb_r <= 8'h00;
      rv_r <= 1'b0;
      rs_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      rb_r <= rb_nxt;
      rv_r <= rv_nxt;
      rs_r <= rs_nxt;
    end
  end

  // Regions; ranging neighbours kept clear by scheduling policy [RL1]
  assign link.slot_count = cnt_r;
  assign link.ranging_region_flag = cfg_ranging_flag;
  assign link.slot_boundary_value = cfg_boundary;
  assign link.ranging_region_now = cnt_r[12:0] < cfg_ranging_end;
  assign link.fixed_region_now = !link.ranging_region_now && cnt_r[12:0] < cfg_fixed_end;
  assign link.resv_region_now = cnt_r[12:0] >= cfg_fixed_end;
  assign link.fixed_assign = cmd_fixed; // Exclusive per connection [RL4]
  assign link.resv_grant = cmd_grant; // [RL5]
  assign link.ranging_assign = cmd_ranging;
  assign link.assign_slot = cmd_slot;
  assign rx_byte = rb_r;
  assign rx_valid = rv_r;
  assign rx_start = rs_r;
endmodule : msf_head
`default_nettype wire

/* File: testbench/msf_link_props.sv */
// Assertions on the upstream burst framing seen on the link
`timescale 1ns/1ns
`default_nettype none
module msf_link_props
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] up_byte,
  input wire logic       up_valid,
  input wire logic       up_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Framing checks; sequences unrolled by hand to keep repeats small
  a_uw_first: assert property (up_start |-> up_valid && up_byte == 8'h00)
    else $error("burst does not open with 00");
  a_uw_tail: assert property (up_start |=> up_byte == 8'hfc ##1 up_byte == 8'hfc
    ##1 up_byte == 8'hf3) else $error("word tail wrong");
  a_sf_byte: assert property (up_start |-> ##4 up_valid && up_byte == 8'h80)
    else $error("start field wrong");
  a_burst_len: assert property (up_start |-> up_valid[*8] ##1 up_valid[*8]
    ##1 up_valid[*4] ##1 !up_valid[*2]) else $error("burst length wrong");
  a_no_restart: assert property (up_start |=> !up_start[*8])
    else $error("burst restarted early");
  a_guard_gap: assert property ($fell(up_valid) |-> !up_valid[*2])
    else $error("guard band too short");
  a_no_gap: assert property (up_valid && !up_start |-> $past(up_valid))
    else $error("gap inside burst");
  a_body_count: assert property ($fell(up_valid) |-> $past(up_start, 20))
    else $error("codeword not 20 bytes after start");
  c_burst: cover property (up_start);
  c_guard: cover property ($fell(up_valid));
  c_back: cover property (up_start ##[22:60] up_start);
endmodule : msf_link_props
`default_nettype wire

/* File: testbench/test_minislot_mac_framer_slot_access.sv */
// Self-checking bench joining the subscriber unit and the head end
`timescale 1ns/1ns
`default_nettype none
module test_minislot_mac_framer_slot_access;
  logic        clk, arst_n, req_valid, req_singlecast, cfg_ranging_flag;
  logic        cmd_fixed, cmd_grant, cmd_ranging, req_ready, burst_done;
  logic        ranging_allowed, rx_valid, rx_start, acc_seen;
  logic [1:0]  req_access;
  logic [7:0]  req_type, rx_byte, first_up;
  logic [47:0] req_mac_addr;
  logic [55:0] req_payload;
  logic [5:0]  cfg_boundary;
  logic [12:0] cfg_ranging_end, cfg_fixed_end, cmd_slot;
  logic [7:0]  rxq[$];
  int          num_errors, checks_done, cycles;

  msf_link_if msf_link_if_inst ();
  msf_unit msf_unit_inst
  (
    .clk(clk), .arst_n(arst_n), .link(msf_link_if_inst), .req_valid(req_valid),
    .req_access(req_access), .req_type(req_type), .req_singlecast(req_singlecast),
    .req_mac_addr(req_mac_addr), .req_payload(req_payload), .req_ready(req_ready),
    .burst_done(burst_done), .ranging_allowed(ranging_allowed)
  );
  msf_head msf_head_inst
  (
    .clk(clk), .arst_n(arst_n), .link(msf_link_if_inst),
    .cfg_ranging_flag(cfg_ranging_flag), .cfg_boundary(cfg_boundary),
    .cfg_ranging_end(cfg_ranging_end), .cfg_fixed_end(cfg_fixed_end),
    .cmd_fixed(cmd_fixed), .cmd_grant(cmd_grant), .cmd_ranging(cmd_ranging),
    .cmd_slot(cmd_slot), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_start(rx_start)
  );
  msf_link_props msf_link_props_inst
  (
    .clk(clk), .arst_n(arst_n), .up_byte(msf_link_if_inst.up_byte),
    .up_valid(msf_link_if_inst.up_valid), .up_start(msf_link_if_inst.up_start)
  );

  // Clock at 10 MHz
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Capture received bytes, the byte flagged as burst start and the access mark; watchdog
  always @(posedge clk)
  begin
    cycles++;
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (rx_start === 1'b1) first_up = rx_byte;
    if (msf_link_if_inst.up_start === 1'b1) acc_seen = msf_link_if_inst.up_access;
    if (cycles == 90000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, seen, want);
    end
  endtask : check

  function automatic logic [7:0] gx(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
  endfunction : gx

  // Head end command pulse, one cycle wide: k is {fixed, grant, ranging}
  task automatic pulse(input logic [2:0] k, input logic [12:0] s);
    cmd_slot = s;
    {cmd_fixed, cmd_grant, cmd_ranging} = k;
    @(negedge clk);
    {cmd_fixed, cmd_grant, cmd_ranging} = 3'b000;
  endtask : pulse

  // Request a burst, wait until taken, then judge every byte received
  task automatic send(input logic [1:0] acc, input logic [7:0] typ, input logic sc);
    logic [7:0] e[20];
    logic [7:0] fb, r1, r0, s0, s1;
    int         n;
    e = '{default: 8'h00};
    e[1] = 8'hfc;
    e[2] = 8'hfc;
    e[3] = 8'hf3;
    e[4] = 8'h80;
    e[5] = typ;
    for (int i = 0; i < 6; i++)
    begin
      e[6 + i] = sc ? req_mac_addr[47 - 8 * i -: 8] : 8'h00;
      e[12 + i] = req_payload[55 - 8 * i -: 8];
    end
    // Leading zero bytes leave the remainder at zero, so start from clear
    {r1, r0} = 16'h0000;
    for (int i = 4; i < 18; i++)
    begin
      fb = e[i] ^ r1;
      r1 = r0 ^ gx(fb) ^ fb;
      r0 = gx(fb);
    end
    e[18] = r1;
    e[19] = r0;
    // Stale marks from the last burst must not pass for this one
    first_up = 8'hff;
    acc_seen = 1'bx;
    rxq = {};
    {req_access, req_type, req_singlecast} = {acc, typ, sc};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    // Done pulse stands only in the cycle after the second guard byte
    repeat (22) @(negedge clk);
    check(burst_done, 8'h01);
    repeat (2) @(negedge clk);
    check(8'(rxq.size()), 8'd20);
    check(first_up, 8'h00);
    check({7'h00, acc_seen}, {7'h00, acc != 2'b00});
    for (int i = 0; i < 20; i++)
      check(rxq[i], e[i]);
    // Received codeword must vanish at both generator roots, 1 and 2
    {s0, s1} = 16'h0000;
    for (int i = 4; i < 20; i++)
    begin
      s0 = s0 ^ rxq[i];
      s1 = gx(s1) ^ rxq[i];
    end
    check(s0, 8'h00);
    check(s1, 8'h00);
  endtask : send

  task automatic t_range();
    cfg_boundary = 6'h36;
    repeat (2) @(negedge clk);
    check(ranging_allowed, 8'h00);
    cfg_boundary = 6'h37;
    repeat (2) @(negedge clk);
    check(ranging_allowed, 8'h01);
    send(2'b00, 8'h22, 1'b1);
    pulse(3'b001, msf_link_if_inst.slot_count[12:0] + 13'd40); // Neighbours left unassigned
    check(ranging_allowed, 8'h00);
    cfg_boundary = 6'h3f;
    send(2'b00, 8'h00, 1'b0);
  endtask : t_range

  task automatic t_fixed_resv();
    rxq = {};
    {req_access, req_valid} = {2'b10, 1'b1};
    repeat (300) @(negedge clk);
    check({7'h00, req_ready}, 8'h00);
    req_valid = 1'b0;
    check(8'(rxq.size()), 8'd0);
    pulse(3'b100, 13'h0050);
    send(2'b01, 8'h00, 1'b0);
    pulse(3'b010, 13'h0100);
    send(2'b10, 8'h22, 1'b1);
    pulse(3'b010, 13'h0050);
    send(2'b11, 8'h22, 1'b1);
  endtask : t_fixed_resv

  // Park at the falling edge where the slot counter shows s; watchdog guards a hang
  task automatic wait_slot(input logic [15:0] s);
    int n;
    n = 0;
    while (msf_link_if_inst.slot_count !== s && n < 70000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_slot

  // Ranging flag counts only after the slot count reaching zero has sampled it
  task automatic t_flag();
    cfg_ranging_flag = 1'b1;
    cfg_boundary = 6'h36;
    wait_slot(16'h6003);
    check(ranging_allowed, 8'h00);
    wait_slot(16'h0003);
    check(ranging_allowed, 8'h01);
  endtask : t_flag

  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Reset for five cycles, then run the scenarios
  initial
  begin
    {arst_n, req_valid, req_access, req_type, req_singlecast} = '0;
    {cfg_ranging_flag, cfg_boundary, cmd_fixed, cmd_grant, cmd_ranging, cmd_slot} = '0;
    req_mac_addr = 48'h0a1b2c3d4e5f;
    req_payload = 56'h11223344556677;
    cfg_ranging_end = 13'h0040;
    cfg_fixed_end = 13'h0080;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    t_range();
    t_fixed_resv();
    t_flag();
    complete_run();
  end
endmodule : test_minislot_mac_framer_slot_access
`default_nettype wire
